// *** verilog/card_response_framer.v ***
// card response framer: serialises R1, R1b, R2, R3 on the command line
// assumes the command decoder gives index and events on clk_i, and that
// the bus clock arrives as a pin and is sampled here
//
// Contract
// - every field goes out MSB first
// - R1 is 48 bits with status and CRC
// - R1b is R1 plus optional data busy
// - R2 is 136 bits, reserved, register bits
// - register bit 0 replaced by end bit
// - identification for 2,10; specific data for 9
// - R3 is 48 bits around the voltage field
// - command 1 answered with voltage window
// - top voltage bit doubles as ready flag
// - R1 carries current status word
// - previous-command bits last one command
// - bit 31 argument bounds, clear on read
// - bit 30 misaligned address, clear on read
// - bit 29 transfer size, clear on read
// - bits 28, 27 erase faults, clear on read
// - bit 26 protected write, clear on read
// - bit 25 follows lock state
// - bit 24 lock failure, clear on read
// - bit 23 checksum fault, previous command
// - bit 22 disallowed request, previous command
// - bits 21..19 internal faults, clear on read
// - bits 18, 17 stream faults, clear on read
// - bits 12..9 show present state
// - response starts 2 to 64 cycles later
`include "resp_framer_defines.vh"

module card_response_framer #(
    parameter [6:0] RESP_GAP = `RESP_GAP_DEFAULT
) (
    input  wire         clk_i,
    input  wire         rstn_i,
    input  wire         bus_clk_i,
    input  wire         cmd_valid_i,
    input  wire [5:0]   cmd_index_i,
    input  wire         cmd_crc_ok_i,
    input  wire         cmd_no_resp_i,
    input  wire         busy_after_i,
    input  wire         status_query_i,
    input  wire [31:0]  status_event_i,
    input  wire         locked_i,
    input  wire [3:0]   card_state_i,
    input  wire         power_ready_i,
    input  wire [127:0] identification_register_i,
    input  wire [127:0] card_specific_data_register_i,
    input  wire         busy_done_i,
    output reg          cmd_o,
    output reg          cmd_oe_o,
    output reg          dat0_o,
    output reg          dat0_oe_o,
    output reg          resp_busy_o,
    output reg  [31:0]  card_status_word_o
);

    // ***************************************************************
    // states
    // ***************************************************************
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_WAIT = 4'b0010;
    localparam [3:0] ST_SEND = 4'b0100;
    localparam [3:0] ST_BUSY = 4'b1000;

    reg  [3:0]   state;
    reg  [2:0]   bclk_sync;
    reg  [1:0]   kind;
    reg  [135:0] frame;
    reg  [7:0]   bits_left;
    reg  [6:0]   gap;
    reg  [5:0]   crc_slot;
    reg  [7:0]   sent;
    reg          hold_busy;
    wire         bclk_fall;
    wire         shift_now;
    wire [6:0]   crc;
    wire [31:0]  status_word;
    wire         crc_clear;
    wire         crc_shift;
    wire [31:0]  ocr_field;

    // ***************************************************************
    // bus clock sampling: output changes on the falling edge
    // ***************************************************************
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bclk_sync <= 3'h0;
        end else begin
            bclk_sync <= {bclk_sync[1:0], bus_clk_i};
        end
    end

    // only stages two and three are compared, stage one stays private
    assign bclk_fall = bclk_sync[2] & ~bclk_sync[1];
    assign shift_now = (state == ST_SEND) & bclk_fall;

    // ***************************************************************
    // status word
    // ***************************************************************
    resp_status_word u_status (
        .clk_i       (clk_i),
        .rstn_i      (rstn_i),
        .event_i     (status_event_i),
        .lock_i      (locked_i),
        .state_i     (card_state_i),
        .valid_cmd_i (cmd_valid_i & cmd_crc_ok_i),
        .read_i      (shift_now & (bits_left == 8'd1) & (kind != `KIND_R2)
                      & (kind != `KIND_R3)),
        .word_o      (status_word)
    );

    // ***************************************************************
    // checksum over the first 40 bits of a short frame
    // ***************************************************************
    assign crc_clear = (state == ST_WAIT);
    assign crc_shift = shift_now & (sent < 8'd40);

    resp_crc7 u_crc (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .clear_i (crc_clear),
        .shift_i (crc_shift),
        .bit_i   (frame[135]),
        .crc_o   (crc)
    );

    // ready flag lives in the top voltage bit
    assign ocr_field = power_ready_i ? `OCR_READY_VALUE
                     : (`OCR_READY_VALUE & ~(32'h1 << `OCR_READY_BIT));

    // ***************************************************************
    // framing state machine
    // ***************************************************************
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state       <= ST_IDLE;
            kind        <= `KIND_R1;
            frame       <= 136'h0;
            bits_left   <= 8'h0;
            gap         <= 7'h0;
            crc_slot    <= 6'h0;
            sent        <= 8'h0;
            hold_busy   <= 1'b0;
            cmd_o       <= 1'b1;
            cmd_oe_o    <= 1'b0;
            dat0_o      <= 1'b1;
            dat0_oe_o   <= 1'b0;
            resp_busy_o <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    cmd_oe_o  <= 1'b0;
                    cmd_o     <= 1'b1;
                    dat0_oe_o <= 1'b0;
                    if (cmd_valid_i & cmd_crc_ok_i & ~cmd_no_resp_i) begin
                        resp_busy_o <= 1'b1;
                        gap         <= 7'h0;
                        sent        <= 8'h0;
                        hold_busy   <= busy_after_i;
                        state       <= ST_WAIT;
                        if (cmd_index_i == `CMD_OP_COND) begin
                            kind      <= `KIND_R3;
                            bits_left <= `FRAME_SHORT_LEN;
                            frame     <= {`R3_HEAD, ocr_field, `R3_TAIL, 88'h0};
                        end else if ((cmd_index_i == `CMD_SEND_ID)
                                     | (cmd_index_i == `CMD_SEND_ID_ADDR)) begin
                            kind      <= `KIND_R2;
                            bits_left <= `FRAME_LONG_LEN;
                            frame     <= {8'h3F, identification_register_i[127:1],
                                          1'b1};
                        end else if (cmd_index_i == `CMD_SEND_SPECIFIC) begin
                            kind      <= `KIND_R2;
                            bits_left <= `FRAME_LONG_LEN;
                            frame     <= {8'h3F, card_specific_data_register_i[127:1],
                                          1'b1};
                        end else begin
                            kind      <= busy_after_i ? `KIND_R1B : `KIND_R1;
                            bits_left <= `FRAME_SHORT_LEN;
                            crc_slot  <= cmd_index_i;
                            frame     <= 136'h0; // status is loaded at start
                        end
                    end
                end
                ST_WAIT: begin
                    // gap counted in bus clock cycles before the start bit
                    if (bclk_fall) begin
                        gap <= gap + 7'd1;
                        if (gap + 7'd1 >= RESP_GAP) begin
                            state <= ST_SEND;
                            if ((kind == `KIND_R1) | (kind == `KIND_R1B)) begin
                                // status sampled as late as possible
                                frame <= {2'b00, crc_slot, status_word,
                                          8'h01, 88'h0};
                            end
                        end
                    end
                end
                ST_SEND: begin
                    if (bclk_fall & (bits_left == 8'd0)) begin
                        // end bit has stood a full bus clock period, release now
                        cmd_oe_o <= 1'b0;
                        cmd_o    <= 1'b1;
                        state    <= hold_busy ? ST_BUSY : ST_IDLE;
                    end else if (bclk_fall) begin
                        cmd_oe_o  <= 1'b1;
                        sent      <= sent + 8'd1;
                        bits_left <= bits_left - 8'd1;
                        if (((kind == `KIND_R1) | (kind == `KIND_R1B)) & (sent >= 8'd40)
                            & (sent < 8'd47)) begin
                            cmd_o <= crc[6 - (sent[2:0] - 3'd0)];
                        end else begin
                            cmd_o <= frame[135];
                        end
                        frame <= {frame[134:0], 1'b1};
                    end
                end
                ST_BUSY: begin
                    if (bclk_fall) begin
                        cmd_oe_o  <= 1'b0;
                        cmd_o     <= 1'b1;
                        dat0_oe_o <= ~busy_done_i;
                        dat0_o    <= 1'b0;
                        if (busy_done_i) begin
                            state <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
            if ((state == ST_IDLE) & ~(cmd_valid_i & cmd_crc_ok_i & ~cmd_no_resp_i)) begin
                resp_busy_o <= 1'b0;
            end
        end
    end

    // status mirror for the command decoder
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            card_status_word_o <= `ST_RESET_VALUE;
        end else begin
            card_status_word_o <= status_word;
        end
    end

endmodule

// *** verilog/resp_framer_defines.vh ***
// shared constants for the card response framer
// assumes inclusion by bare name from the design files
`ifndef RESP_FRAMER_DEFINES_VH
`define RESP_FRAMER_DEFINES_VH

// ***************************************************************
// frame lengths and kinds
// ***************************************************************
`define FRAME_SHORT_LEN     8'd48
`define FRAME_LONG_LEN      8'd136
`define KIND_R1             2'h0
`define KIND_R1B            2'h1
`define KIND_R2             2'h2
`define KIND_R3             2'h3

// ***************************************************************
// command indices answered with fixed formats
// ***************************************************************
`define CMD_OP_COND         6'h01
`define CMD_SEND_ID         6'h02
`define CMD_SEND_SPECIFIC   6'h09
`define CMD_SEND_ID_ADDR    6'h0A

// ***************************************************************
// operating condition and R3 fields
// ***************************************************************
`define OCR_READY_VALUE     32'h80FF8000
`define OCR_READY_BIT       31
`define R3_HEAD             8'h3F
`define R3_TAIL             8'hFF

// ***************************************************************
// status word layout
// ***************************************************************
`define ST_ARG_BOUNDS       31
`define ST_MISALIGN         30
`define ST_XFER_SIZE        29
`define ST_ERASE_ORDER      28
`define ST_ERASE_SEL        27
`define ST_PROT_WRITE       26
`define ST_LOCK             25
`define ST_LOCK_FAIL        24
`define ST_CHECKSUM         23
`define ST_DISALLOWED       22
`define ST_ECC_FAIL         21
`define ST_CTRL_FAULT       20
`define ST_GENERAL          19
`define ST_UNDERRUN         18
`define ST_OVERRUN          17
`define ST_STATE_HI         12
`define ST_STATE_LO         9
// bits cleared by a status read: 31..26, 24, 21..17
`define ST_CLEAR_ON_READ    32'hFD3E0000
`define ST_RESET_VALUE      32'h00000000

// ***************************************************************
// response timing in link clock cycles
// ***************************************************************
`define RESP_GAP_MIN        7'd2
`define RESP_GAP_MAX        7'd64
`define RESP_GAP_DEFAULT    7'd2

`endif

// *** verilog/resp_crc7.v ***
// serial 7-bit checksum, generator x^7 + x^3 + 1
// assumes shift_i pulses once per frame bit and clear_i before a frame
`include "resp_framer_defines.vh"

module resp_crc7 (
    input  wire       clk_i,
    input  wire       rstn_i,
    input  wire       clear_i,
    input  wire       shift_i,
    input  wire       bit_i,
    output reg  [6:0] crc_o
);

    wire fb;

    assign fb = bit_i ^ crc_o[6];

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            crc_o <= 7'h00;
        end else if (clear_i) begin
            crc_o <= 7'h00;
        end else if (shift_i) begin
            crc_o <= {crc_o[5:3], crc_o[2] ^ fb, crc_o[1:0], fb};
        end
    end

endmodule

// *** verilog/resp_status_word.v ***
// card status word with set, clear-on-read and previous-command rules
// assumes event pulses come from logic on the same clock
`include "resp_framer_defines.vh"

module resp_status_word (
    input  wire        clk_i,
    input  wire        rstn_i,
    input  wire [31:0] event_i,
    input  wire        lock_i,
    input  wire [3:0]  state_i,
    input  wire        valid_cmd_i,
    input  wire        read_i,
    output reg  [31:0] word_o
);

    wire [31:0] cor_mask;
    wire [31:0] prev_mask;
    wire [31:0] sticky_mask;
    reg  [1:0]  prev_pend;
    reg  [1:0]  prev_hold;

    assign cor_mask    = `ST_CLEAR_ON_READ;
    assign sticky_mask = cor_mask;
    assign prev_mask   = (32'h1 << `ST_CHECKSUM) | (32'h1 << `ST_DISALLOWED);

    // ***************************************************************
    // previous-command bits: visible for exactly the next command
    // ***************************************************************
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prev_pend <= 2'h0;
            prev_hold <= 2'h0;
        end else begin
            if (valid_cmd_i) begin
                // the pending flags become visible, older ones retire
                prev_hold <= prev_pend | {event_i[`ST_CHECKSUM], event_i[`ST_DISALLOWED]};
                prev_pend <= 2'h0;
            end else begin
                prev_pend <= prev_pend | {event_i[`ST_CHECKSUM], event_i[`ST_DISALLOWED]};
            end
        end
    end

    // ***************************************************************
    // clear-on-read bits: a set in the read cycle wins over the clear
    // ***************************************************************
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            word_o <= `ST_RESET_VALUE;
        end else begin
            word_o <= ((word_o & sticky_mask & ~(read_i ? cor_mask : 32'h0))
                       | (event_i & sticky_mask))
                      | ({30'h0, prev_hold[1], prev_hold[0]} << `ST_DISALLOWED) & prev_mask
                      | ({31'h0, lock_i} << `ST_LOCK)
                      | ({28'h0, state_i} << `ST_STATE_LO);
        end
    end

endmodule

// *** verif/card_response_framer_asserts.sv ***
// port-level checks for the card response framer
// assumes bus clock runs at 8 clk periods in the bench
module card_response_framer_asserts #(
    parameter [6:0] RESP_GAP = 7'd2
) (
    input wire logic        clk_i,
    input wire logic        rstn_i,
    input wire logic        cmd_valid_i,
    input wire logic        cmd_crc_ok_i,
    input wire logic        cmd_no_resp_i,
    input wire logic        locked_i,
    input wire logic [3:0]  card_state_i,
    input wire logic        busy_done_i,
    input wire logic        cmd_o,
    input wire logic        cmd_oe_o,
    input wire logic        dat0_o,
    input wire logic        dat0_oe_o,
    input wire logic        resp_busy_o,
    input wire logic [31:0] card_status_word_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // ****************************************
    // framing, timing, busy and status mirror checks
    // ****************************************
    start_bit_a: assert property ($rose(cmd_oe_o) |-> !cmd_o)
        else $error("frame did not open with a zero");
    end_bit_a: assert property ($fell(cmd_oe_o) |-> $past(cmd_o))
        else $error("frame did not close with a one");
    oe_in_busy_a: assert property (cmd_oe_o |-> resp_busy_o)
        else $error("line driven outside a response");
    accept_a: assert property (cmd_valid_i && cmd_crc_ok_i && !cmd_no_resp_i && !resp_busy_o
        |=> resp_busy_o) else $error("command not taken");
    no_reply_a: assert property (cmd_valid_i && !cmd_crc_ok_i && !resp_busy_o
        |=> !resp_busy_o) else $error("reply to a failed command");
    gap_min_a: assert property ($rose(resp_busy_o) |-> !cmd_oe_o [*8])
        else $error("response started too early");
    gap_max_a: assert property ($rose(resp_busy_o) |-> ##[1:1000] cmd_oe_o)
        else $error("response started too late");
    busy_low_a: assert property (dat0_oe_o |-> !dat0_o)
        else $error("busy drive not low");
    busy_release_a: assert property (dat0_oe_o && busy_done_i |-> ##[1:32] !dat0_oe_o)
        else $error("busy not released");
    lock_mirror_a: assert property ($stable(locked_i) [*4]
        |-> card_status_word_o[25] == locked_i) else $error("lock bit wrong");
    state_mirror_a: assert property ($stable(card_state_i) [*4]
        |-> card_status_word_o[12:9] == card_state_i) else $error("state field wrong");
endmodule

bind card_response_framer card_response_framer_asserts #(.RESP_GAP(RESP_GAP)) u_asserts (
    .clk_i(clk_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid_i), .cmd_crc_ok_i(cmd_crc_ok_i),
    .cmd_no_resp_i(cmd_no_resp_i), .locked_i(locked_i), .card_state_i(card_state_i),
    .busy_done_i(busy_done_i), .cmd_o(cmd_o), .cmd_oe_o(cmd_oe_o), .dat0_o(dat0_o),
    .dat0_oe_o(dat0_oe_o), .resp_busy_o(resp_busy_o),
    .card_status_word_o(card_status_word_o));

// *** verif/host_model.sv ***
// host side: makes the bus clock and samples the command line
// assumes card bits change on falling bus clock edges
module host_model (
    input  wire logic         run_i,
    input  wire logic         clr_i,
    input  wire logic         cmd_i,
    input  wire logic         cmd_oe_i,
    output logic              bus_clk_o,
    output logic [135:0]      frame_o,
    output logic [7:0]        count_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // pull-up keeps a released line high
    wire line = cmd_oe_i ? cmd_i : 1'b1;
    // clock stands low outside transfers
    initial begin
        bus_clk_o = 1'b0;
        forever begin
            #200;
            bus_clk_o = run_i ? ~bus_clk_o : 1'b0;
        end
    end
    always @(posedge bus_clk_o or posedge clr_i) begin
        if (clr_i) begin
            frame_o <= '0;
            count_o <= 8'h00;
        end else if (cmd_oe_i) begin
            frame_o <= {frame_o[134:0], line};
            count_o <= count_o + 8'h01;
        end
    end
endmodule

// *** verif/testbench.sv ***
// self-checking bench for the card response framer
// assumes host_model and the bound checker are compiled alongside
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic         clk_i, rstn_i, cmd_valid_i, cmd_crc_ok_i, cmd_no_resp_i, busy_after_i;
    logic         status_query_i, locked_i, power_ready_i, busy_done_i, run, clr;
    logic [5:0]   cmd_index_i;
    logic [31:0]  status_event_i, base;
    logic [3:0]   card_state_i;
    logic [127:0] id_reg, csd_reg, want;
    logic [5:0]   r2_idx [3] = '{6'h02, 6'h0A, 6'h09};
    wire          bus_clk, cmd_o, cmd_oe_o, dat0_o, dat0_oe_o, resp_busy_o;
    wire [31:0]   card_status_word_o;
    wire [135:0]  frame;
    wire [7:0]    count;
    int           failures, comparisons;

    card_response_framer #(.RESP_GAP(7'd4)) u_dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .bus_clk_i(bus_clk), .cmd_valid_i(cmd_valid_i),
        .cmd_index_i(cmd_index_i), .cmd_crc_ok_i(cmd_crc_ok_i), .cmd_no_resp_i(cmd_no_resp_i),
        .busy_after_i(busy_after_i), .status_query_i(status_query_i),
        .status_event_i(status_event_i), .locked_i(locked_i), .card_state_i(card_state_i),
        .power_ready_i(power_ready_i), .identification_register_i(id_reg),
        .card_specific_data_register_i(csd_reg), .busy_done_i(busy_done_i), .cmd_o(cmd_o),
        .cmd_oe_o(cmd_oe_o), .dat0_o(dat0_o), .dat0_oe_o(dat0_oe_o),
        .resp_busy_o(resp_busy_o), .card_status_word_o(card_status_word_o));
    host_model u_host (.run_i(run), .clr_i(clr), .cmd_i(cmd_o), .cmd_oe_i(cmd_oe_o),
        .bus_clk_o(bus_clk), .frame_o(frame), .count_o(count));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input logic [135:0] seen, input logic [135:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [6:0] crc7(input logic [39:0] d);
        logic [6:0] c;
        logic       fb;
        c = 7'h00;
        for (int i = 39; i >= 0; i--) begin
            fb = d[i] ^ c[6];
            c = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
        end
        return c;
    endfunction
    // bus clock is kept running a little past the frame for the busy phase
    task automatic send(input logic [5:0] idx, input logic ok, input logic [31:0] ev,
                        input int bits);
        clr <= 1'b1;
        run <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        cmd_valid_i <= 1'b1;
        cmd_index_i <= idx;
        cmd_crc_ok_i <= ok;
        status_event_i <= ev;
        @(posedge clk_i);
        cmd_valid_i <= 1'b0;
        status_event_i <= 32'h00000000;
        for (int i = 0; bits > 0 && i < 3000 && !(count == bits && !cmd_oe_o); i++)
            @(posedge clk_i);
        repeat (16) @(posedge clk_i);
        run <= 1'b0;
        repeat (16) @(posedge clk_i);
    endtask
    task automatic r1(input logic [5:0] idx, input logic [31:0] ev, input logic [31:0] st);
        logic [39:0] head;
        head = {2'b00, idx, st};
        send(idx, 1'b1, ev, 48);
        check(frame[47:0], {head, crc7(head), 1'b1});
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ****************************************
    // stimulus
    // ****************************************
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    initial begin
        #4000000;
        failures++;
        tally_and_finish();
    end
    initial begin
        {rstn_i, cmd_valid_i, cmd_crc_ok_i, cmd_no_resp_i, busy_after_i} = '0;
        {status_query_i, locked_i, power_ready_i, busy_done_i, run, clr} = '0;
        cmd_index_i = 6'h00;
        status_event_i = 32'h00000000;
        card_state_i = 4'h0;
        id_reg = 128'h0123456789ABCDEF_FEDCBA9876543211;
        csd_reg = 128'hA5C3_1E0F_5A3C_E1F0_0F1E_C3A5_F0E1_3C5B;
        repeat (16) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        for (int r = 0; r < 2; r++) begin
            power_ready_i <= r[0];
            send(6'h01, 1'b1, 32'h0, 48);
            check(frame[47:0], r ? 48'h3F80FF8000FF : 48'h3F00FF8000FF);
        end
        foreach (r2_idx[k]) begin
            want = (k < 2) ? id_reg : csd_reg;
            send(r2_idx[k], 1'b1, 32'h0, 136);
            check(frame, {8'h3F, want[127:1], 1'b1});
        end
        locked_i <= 1'b1;
        card_state_i <= 4'h4;
        base = 32'h02000800;
        // host polls status to see execution-time bits
        for (int b = 17; b < 32; b++) begin
            if (32'hFD3E0000 & (32'h1 << b)) begin
                r1(6'h0D, 32'h1 << b, base | (32'h1 << b));
                r1(6'h0D, 32'h0, base);
            end
        end
        for (int b = 22; b < 24; b++) begin
            send(6'h0D, 1'b0, 32'h1 << b, 0);
            r1(6'h0D, 32'h0, base | (32'h1 << b));
            r1(6'h0D, 32'h0, base);
        end
        for (int s = 0; s < 9; s++) begin
            card_state_i <= 4'(s);
            locked_i <= s[0];
            r1(6'h0D, 32'h0, (32'(s) << 9) | (s[0] ? 32'h02000000 : 32'h0));
        end
        busy_after_i <= 1'b1;
        r1(6'h07, 32'h0, 32'h00001000);
        busy_after_i <= 1'b0;
        check({dat0_oe_o, dat0_o}, 2'b10);
        run <= 1'b1;
        busy_done_i <= 1'b1;
        for (int i = 0; i < 64 && dat0_oe_o !== 1'b0; i++) @(posedge clk_i);
        check(dat0_oe_o, 1'b0);
        run <= 1'b0;
        busy_done_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        tally_and_finish();
    end
endmodule
